// ### gr_pkg.sv
// What this block does
// - Registers: 9-bit address, 16-bit value only
// - Configuration words kept thrice, self-correcting by vote
// - Corrected copy mismatch raises a warning pulse
// - Address zero forwards to selected pixel pair
// - Pixel selection comes from row/column registers
// - Fifteen 16-bit diagnostic counters, read and writable
// - Any counter write clears it to zero
// - Each counter counts its own event signal; counter 0 also counts vote warnings
// - Counters saturate at maximum, never wrap
// - Oscillator registers read-only, 12+4 bit fields
// - Low field counts ticks, high counts start/stop
// - Oscillator fields cleared by reset or global pulse only
// - Converter address reads result, writes ignored
// - Scratch words store and return written data
// - Five-bit select enables exactly one of 32
// - Converter step rate is clock divided by 128
// - Twelve-bit successive approximation, one bit per step
// - Read-back carries 10-bit extended address
package gr_pkg;

    localparam int ADDR_W      = 9;
    localparam int EXT_ADDR_W  = 10;
    localparam int DATA_W      = 16;
    localparam int N_CFG       = 8;
    localparam int N_CNT       = 15;
    localparam int N_RING      = 8;
    localparam int N_SCRATCH   = 2;
    localparam int RING_LO_W   = 12;
    localparam int RING_HI_W   = 4;
    localparam int MON_SEL_W   = 5;
    localparam int MON_INPUTS  = 32;
    localparam int ADC_W       = 12;
    localparam int ADC_DIV     = 128;
    localparam int ADC_DIV_W   = 7;

    localparam logic [ADDR_W-1:0] OFS_PORTAL   = 9'h000;
    localparam logic [ADDR_W-1:0] OFS_CFG      = 9'h001;
    localparam logic [ADDR_W-1:0] OFS_SCRATCH  = 9'h010;
    localparam logic [ADDR_W-1:0] OFS_CNT      = 9'h020;
    localparam logic [ADDR_W-1:0] OFS_RING     = 9'h030;
    localparam logic [ADDR_W-1:0] OFS_ADC      = 9'h03f;

    // Index of configuration words with fixed roles
    localparam int CFG_ROW     = 0;
    localparam int CFG_COL     = 1;
    localparam int CFG_MON     = 2;

    localparam logic [DATA_W-1:0] CFG_RESET    = 16'h0000;
    localparam logic [DATA_W-1:0] SCRATCH_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;

    typedef enum logic [1:0] {
        SAR_IDLE = 2'b00,
        SAR_CONV = 2'b01,
        SAR_DONE = 2'b11
    } gr_sar_state_t;

endpackage

// ### gr_sat_counter.sv
`timescale 1ns/1ns
module gr_sat_counter #(
    parameter int W = 16
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         clear,
    input  wire logic         event_in,
    output logic [W-1:0]      count
);
    always_ff @(posedge mclk) begin
        if (rst) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (event_in && count != {W{1'b1}}) begin
            count <= count + 1'b1;
        end
    end
endmodule

// ### gr_regfile.sv
`timescale 1ns/1ns
module gr_regfile #(
    parameter int N_CNT_P  = gr_pkg::N_CNT,
    parameter int N_RING_P = gr_pkg::N_RING
) (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire logic                          wr_en,
    input  wire logic                          rd_en,
    input  wire logic [gr_pkg::ADDR_W-1:0]     addr,
    input  wire logic [gr_pkg::DATA_W-1:0]     wdata,
    output logic                               rd_valid,
    output logic [gr_pkg::EXT_ADDR_W-1:0]      rd_ext_addr,
    output logic [gr_pkg::DATA_W-1:0]          rdata,
    output logic                               pix_wr,
    output logic                               pix_rd,
    output logic [gr_pkg::DATA_W-1:0]          pix_wdata,
    input  wire logic [gr_pkg::DATA_W-1:0]     pix_rdata,
    output logic [gr_pkg::DATA_W-1:0]          pix_row,
    output logic [gr_pkg::DATA_W-1:0]          pix_col,
    output logic [gr_pkg::N_CFG*gr_pkg::DATA_W-1:0] cfg_words,
    input  wire logic                          single_event_upset,
    input  wire logic [1:0]                    upset_copy,
    input  wire logic [2:0]                    upset_word,
    input  wire logic [gr_pkg::DATA_W-1:0]     upset_mask,
    output logic                               redundancy_mismatch_flag,
    input  wire logic [N_CNT_P-1:0]            cnt_event,
    input  wire logic [N_RING_P-1:0]           ring_tick,
    input  wire logic [N_RING_P-1:0]           ring_startstop,
    input  wire logic                          global_pulse,
    output logic [gr_pkg::MON_INPUTS-1:0]      mon_sel_onehot,
    output logic                               adc_step_en,
    output logic [gr_pkg::ADC_W-1:0]           adc_trial,
    input  wire logic                          adc_cmp,
    output logic                               adc_busy
);
    import gr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    logic                 hit_cfg;
    logic                 hit_scr;
    logic                 hit_cnt;
    logic                 hit_ring;
    logic [ADDR_W-1:0]    rel_cfg;
    logic [ADDR_W-1:0]    rel_scr;
    logic [ADDR_W-1:0]    rel_cnt;
    logic [ADDR_W-1:0]    rel_ring;

    always_comb begin
        rel_cfg  = addr - OFS_CFG;
        rel_scr  = addr - OFS_SCRATCH;
        rel_cnt  = addr - OFS_CNT;
        rel_ring = addr - OFS_RING;
        hit_cfg  = addr >= OFS_CFG && rel_cfg < ADDR_W'(N_CFG);
        hit_scr  = addr >= OFS_SCRATCH && rel_scr < ADDR_W'(N_SCRATCH);
        hit_cnt  = addr >= OFS_CNT && rel_cnt < ADDR_W'(N_CNT_P);
        hit_ring = addr >= OFS_RING && rel_ring < ADDR_W'(N_RING_P);
    end

    ////////////////////////////////////////////////////////////////////////
    // Write strobes; oscillator and converter words get none

    logic [N_CFG-1:0]     wr_cfg;
    logic [N_SCRATCH-1:0] wr_scr;
    logic [N_CNT_P-1:0]   wr_cnt;

    always_comb begin
        wr_cfg = '0;
        wr_scr = '0;
        wr_cnt = '0;
        for (int i = 0; i < N_CFG; i++) begin
            wr_cfg[i] = wr_en && hit_cfg && rel_cfg == ADDR_W'(i);
        end
        for (int i = 0; i < N_SCRATCH; i++) begin
            wr_scr[i] = wr_en && hit_scr && rel_scr == ADDR_W'(i);
        end
        for (int i = 0; i < N_CNT_P; i++) begin
            wr_cnt[i] = wr_en && hit_cnt && rel_cnt == ADDR_W'(i);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pixel portal: no storage, straight through to the pair selected

    always_comb begin
        pix_wr    = wr_en && addr == OFS_PORTAL;
        pix_rd    = rd_en && addr == OFS_PORTAL;
        pix_wdata = wdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration words, three copies with majority vote each cycle

    logic [DATA_W-1:0] copy_a [N_CFG];
    logic [DATA_W-1:0] copy_b [N_CFG];
    logic [DATA_W-1:0] copy_c [N_CFG];
    logic [DATA_W-1:0] voted  [N_CFG];
    logic              any_mismatch;

    always_comb begin
        any_mismatch = 1'b0;
        for (int i = 0; i < N_CFG; i++) begin
            voted[i] = (copy_a[i] & copy_b[i]) | (copy_b[i] & copy_c[i])
                     | (copy_a[i] & copy_c[i]);
            if (copy_a[i] != copy_b[i] || copy_b[i] != copy_c[i]) begin
                any_mismatch = 1'b1;
            end
        end
    end

    // Strike pattern per copy; copy code 3 hits nothing. Only one copy is
    // ever struck, so the vote can always repair it.
    logic [DATA_W-1:0] strike_a [N_CFG];
    logic [DATA_W-1:0] strike_b [N_CFG];
    logic [DATA_W-1:0] strike_c [N_CFG];

    always_comb begin
        for (int i = 0; i < N_CFG; i++) begin
            strike_a[i] = '0;
            strike_b[i] = '0;
            strike_c[i] = '0;
            if (single_event_upset && upset_word == 3'(i)) begin
                case (upset_copy)
                    2'h0: strike_a[i] = upset_mask;
                    2'h1: strike_b[i] = upset_mask;
                    2'h2: strike_c[i] = upset_mask;
                    default: begin
                    end
                endcase
            end
        end
    end

    // Write wins over a strike in the same cycle; a strike lands in one
    // copy and is voted out on the next edge.
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < N_CFG; i++) begin
                copy_a[i] <= CFG_RESET;
                copy_b[i] <= CFG_RESET;
                copy_c[i] <= CFG_RESET;
            end
        end else begin
            for (int i = 0; i < N_CFG; i++) begin
                if (wr_cfg[i]) begin
                    copy_a[i] <= wdata;
                    copy_b[i] <= wdata;
                    copy_c[i] <= wdata;
                end else begin
                    copy_a[i] <= voted[i] ^ strike_a[i];
                    copy_b[i] <= voted[i] ^ strike_b[i];
                    copy_c[i] <= voted[i] ^ strike_c[i];
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            redundancy_mismatch_flag <= 1'b0;
        end else begin
            redundancy_mismatch_flag <= any_mismatch;
        end
    end

    always_comb begin
        for (int i = 0; i < N_CFG; i++) begin
            cfg_words[i*DATA_W +: DATA_W] = voted[i];
        end
        pix_row = voted[CFG_ROW];
        pix_col = voted[CFG_COL];
    end

    ////////////////////////////////////////////////////////////////////////
    // Scratch words

    logic [DATA_W-1:0] scratch_reg [N_SCRATCH];

    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < N_SCRATCH; i++) begin
                scratch_reg[i] <= SCRATCH_RESET;
            end
        end else begin
            for (int i = 0; i < N_SCRATCH; i++) begin
                if (wr_scr[i]) begin
                    scratch_reg[i] <= wdata;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Diagnostic counters; counter 0 also sees the vote warning

    logic [DATA_W-1:0] cnt_val [N_CNT_P];

    for (genvar g = 0; g < N_CNT_P; g++) begin : g_cnt
        logic ev;
        assign ev = (g == 0) ? (cnt_event[g] | redundancy_mismatch_flag)
                             : cnt_event[g];
        gr_sat_counter #(
            .W        (DATA_W)
        ) u_cnt (
            .mclk     (mclk),
            .rst      (rst),
            .clear    (wr_cnt[g]),
            .event_in (ev),
            .count    (cnt_val[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator counters; no write path reaches them

    logic [RING_LO_W-1:0] ring_lo_reg [N_RING_P];
    logic [RING_HI_W-1:0] ring_hi_reg [N_RING_P];

    always_ff @(posedge mclk) begin
        if (rst || global_pulse) begin
            for (int i = 0; i < N_RING_P; i++) begin
                ring_lo_reg[i] <= '0;
                ring_hi_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < N_RING_P; i++) begin
                if (ring_tick[i]) begin
                    ring_lo_reg[i] <= ring_lo_reg[i] + 1'b1;
                end
                if (ring_startstop[i]) begin
                    ring_hi_reg[i] <= ring_hi_reg[i] + 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Monitor selector and converter
    // Divider runs from reset on, so steps never bunch after a write

    logic [ADC_DIV_W-1:0] div_reg;
    gr_sar_state_t        sar_reg;
    logic [ADC_W-1:0]     sar_bit_reg;
    logic [ADC_W-1:0]     adc_result_reg;

    always_comb begin
        mon_sel_onehot = '0;
        mon_sel_onehot[voted[CFG_MON][MON_SEL_W-1:0]] = 1'b1;
        adc_step_en = div_reg == ADC_DIV_W'(ADC_DIV - 1);
        adc_busy    = sar_reg == SAR_CONV;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // Free running: done returns to idle, and a new conversion starts at the step after that, so
    // the result word is at most one conversion old.
    always_ff @(posedge mclk) begin
        if (rst) begin
            sar_reg        <= SAR_IDLE;
            sar_bit_reg    <= '0;
            adc_trial      <= '0;
            adc_result_reg <= '0;
        end else if (adc_step_en) begin
            case (sar_reg)
                SAR_IDLE: begin
                    sar_reg     <= SAR_CONV;
                    sar_bit_reg <= {1'b1, {(ADC_W-1){1'b0}}};
                    adc_trial   <= {1'b1, {(ADC_W-1){1'b0}}};
                end
                SAR_CONV: begin
                    // One bit decided per step, MSB first
                    if (!adc_cmp) begin
                        adc_trial <= (adc_trial & ~sar_bit_reg)
                                   | (sar_bit_reg >> 1);
                    end else begin
                        adc_trial <= adc_trial | (sar_bit_reg >> 1);
                    end
                    sar_bit_reg <= sar_bit_reg >> 1;
                    if (sar_bit_reg[0]) begin
                        sar_reg        <= SAR_DONE;
                        adc_result_reg <= adc_cmp ? adc_trial
                                        : (adc_trial & ~sar_bit_reg);
                    end
                end
                SAR_DONE: begin
                    sar_reg <= SAR_IDLE;
                end
                default: begin
                    sar_reg <= SAR_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read-back; answered on the edge after the request

    logic [DATA_W-1:0]     rd_mux;
    logic [EXT_ADDR_W-1:0] ext_mux;

    always_comb begin
        rd_mux  = UNMAPPED_READ;
        ext_mux = {1'b0, addr};
        if (addr == OFS_PORTAL) begin
            rd_mux  = pix_rdata;
            ext_mux = {1'b1, voted[CFG_ROW][ADDR_W-1:0]};
        end else if (hit_cfg) begin
            rd_mux = voted[rel_cfg[2:0]];
        end else if (hit_scr) begin
            rd_mux = scratch_reg[rel_scr[0]];
        end else if (hit_cnt) begin
            rd_mux = cnt_val[rel_cnt[3:0]];
        end else if (hit_ring) begin
            rd_mux = {ring_hi_reg[rel_ring[2:0]],
                      ring_lo_reg[rel_ring[2:0]]};
        end else if (addr == OFS_ADC) begin
            rd_mux = {4'h0, adc_result_reg};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_valid    <= 1'b0;
            rd_ext_addr <= '0;
            rdata       <= '0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_ext_addr <= ext_mux;
                rdata       <= rd_mux;
            end
        end
    end

endmodule

// ### gr_regfile_props.sv
`timescale 1ns/1ns
module gr_regfile_props (
    input wire logic                              mclk,
    input wire logic                              rst,
    input wire logic                              wr_en,
    input wire logic                              rd_en,
    input wire logic [gr_pkg::ADDR_W-1:0]         addr,
    input wire logic                              rd_valid,
    input wire logic [gr_pkg::EXT_ADDR_W-1:0]     rd_ext_addr,
    input wire logic [gr_pkg::DATA_W-1:0]         rdata,
    input wire logic                              pix_rd,
    input wire logic [gr_pkg::DATA_W-1:0]         pix_row,
    input wire logic [gr_pkg::N_CFG*gr_pkg::DATA_W-1:0] cfg_words,
    input wire logic                              single_event_upset,
    input wire logic [1:0]                        upset_copy,
    input wire logic [gr_pkg::DATA_W-1:0]         upset_mask,
    input wire logic                              redundancy_mismatch_flag,
    input wire logic [gr_pkg::MON_INPUTS-1:0]     mon_sel_onehot,
    input wire logic                              adc_step_en,
    input wire logic [gr_pkg::ADC_W-1:0]          adc_trial,
    input wire logic                              adc_busy
);
    import gr_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // Mirror of the divider, so a drifting step rate shows at once
    logic [6:0] gap_reg;
    always_ff @(posedge mclk) begin
        gap_reg <= (rst || adc_step_en) ? 7'h00 : gap_reg + 7'h01;
    end
    sequence cnt_wr_then_rd;
        wr_en && addr >= OFS_CNT && addr <= OFS_CNT + 9'h00e
        ##1 rd_en && !wr_en && addr == $past(addr);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    read_answer_a: assert property (rd_valid == $past(rd_en))
        else $error("read answer not one cycle after request");
    portal_forward_a: assert property (
        pix_rd == (rd_en && addr == 9'h000))
        else $error("portal read not forwarded");
    ext_addr_a: assert property (rd_en && addr != 9'h000 |=>
        rd_ext_addr == {1'b0, $past(addr)})
        else $error("bad extended address");
    portal_ext_a: assert property (rd_en && addr == 9'h000 |=>
        rd_ext_addr == {1'b1, $past(pix_row[8:0])})
        else $error("bad row address");
    mux_onehot_a: assert property ($onehot(mon_sel_onehot) &&
        mon_sel_onehot == 32'h1 << cfg_words[CFG_MON*16 +: 5])
        else $error("monitor select not one of 32");
    step_rate_a: assert property (
        adc_step_en == (gap_reg == 7'h7f))
        else $error("converter step not every 128 cycles");
    sar_start_a: assert property (adc_busy && !$past(adc_busy) |->
        adc_trial == 12'h800)
        else $error("conversion not started at midscale");
    count_clear_a: assert property (
        cnt_wr_then_rd |=> rdata == 16'h0000)
        else $error("counter not zero after clearing write");
    upset_flag_a: assert property (single_event_upset && !wr_en &&
        upset_copy != 2'b11 && upset_mask != 16'h0000 |-> ##[1:2]
        redundancy_mismatch_flag) else $error("copy mismatch not flagged");
endmodule
bind gr_regfile gr_regfile_props u_props (.mclk(mclk), .rst(rst),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .rd_valid(rd_valid),
    .rd_ext_addr(rd_ext_addr), .rdata(rdata), .pix_rd(pix_rd),
    .pix_row(pix_row), .cfg_words(cfg_words),
    .single_event_upset(single_event_upset), .upset_copy(upset_copy),
    .upset_mask(upset_mask),
    .redundancy_mismatch_flag(redundancy_mismatch_flag),
    .mon_sel_onehot(mon_sel_onehot), .adc_step_en(adc_step_en),
    .adc_trial(adc_trial), .adc_busy(adc_busy));

// ### gr_cmd_model.sv
`timescale 1ns/1ns
module gr_cmd_model (
    input wire logic            mclk,
    output logic                wr_en,
    output logic                rd_en,
    output logic [8:0]          addr,
    output logic [15:0]         wdata,
    input wire logic            rd_valid,
    input wire logic [15:0]     rdata
);
    ////////////////////////////////////////////////////////////////////////
    // Bus idle from time zero, so nothing unknown reaches the block
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr  = '0;
        wdata = '0;
    end
    // One request per cycle; idle lines show inverted values, not stale ones
    task automatic req(input logic w, input logic r, input logic [8:0] a,
                       input logic [15:0] d);
        @(posedge mclk);
        #2;
        wr_en = w;
        rd_en = r;
        addr  = (w || r) ? a : ~a;
        wdata = w ? d : ~d;
    endtask
    task automatic write_reg(input logic [8:0] a, input logic [15:0] d);
        req(1'b1, 1'b0, a, d);
        req(1'b0, 1'b0, a, d);
    endtask
    task automatic read_reg(input logic [8:0] a, output logic [15:0] d,
                            output logic v);
        req(1'b0, 1'b1, a, 16'h0000);
        req(1'b0, 1'b0, a, 16'h0000);
        d = rdata;
        v = rd_valid;
    endtask
    // Start-up: every event counter written once so all begin at zero
    task automatic clear_counters();
        for (int i = 0; i < 15; i++) begin
            write_reg(9'h020 + 9'(i), 16'hffff);
        end
    endtask
endmodule

// ### global_register_file_tb.sv
`timescale 1ns/1ns
module global_register_file_tb;
    import gr_pkg::*;
    logic mclk, rst, wr_en, rd_en, rd_valid, pix_wr, pix_rd, sea, flag;
    logic global_pulse, adc_cmp, adc_step_en, adc_busy, v;
    logic [8:0] addr, a;
    logic [9:0] rd_ext_addr;
    logic [15:0] wdata, rdata, pix_wdata, pix_rdata, pix_row, pix_col, d, w;
    logic [15:0] upset_mask, exp_cfg [10];
    logic [127:0] cfg_words;
    logic [1:0] upset_copy;
    logic [2:0] upset_word;
    logic [14:0] cnt_event;
    logic [7:0] ring_tick, ring_ss;
    logic [31:0] onehot;
    logic [11:0] trial, vin;
    integer seed, miscompares, cmp_count, cyc;
    assign adc_cmp = vin >= trial;
    gr_regfile DUT (.mclk(mclk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wdata(wdata), .rd_valid(rd_valid),
        .rd_ext_addr(rd_ext_addr), .rdata(rdata), .pix_wr(pix_wr),
        .pix_rd(pix_rd), .pix_wdata(pix_wdata), .pix_rdata(pix_rdata),
        .pix_row(pix_row), .pix_col(pix_col), .cfg_words(cfg_words),
        .single_event_upset(sea), .upset_copy(upset_copy),
        .upset_word(upset_word), .upset_mask(upset_mask),
        .redundancy_mismatch_flag(flag), .cnt_event(cnt_event),
        .ring_tick(ring_tick), .ring_startstop(ring_ss),
        .global_pulse(global_pulse), .mon_sel_onehot(onehot),
        .adc_step_en(adc_step_en), .adc_trial(trial), .adc_cmp(adc_cmp),
        .adc_busy(adc_busy));
    gr_cmd_model u_cmd (.mclk(mclk), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wdata(wdata), .rd_valid(rd_valid), .rdata(rdata));
    ////////////////////////////////////////////////////////////////////////
    always #20 mclk = ~mclk;
    // Longest test is counter saturation, some 66k cycles
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 90000) begin
            miscompares = miscompares + 1;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [8:0] ra, output logic [15:0] rv);
        u_cmd.read_reg(ra, rv, v);
        chk(v, 1);
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    function automatic logic [15:0] osc_word(input int hi, input int lo);
        return {4'(hi), 12'(lo)};
    endfunction
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 0; rst = 1;
        sea = 0; upset_copy = 0; upset_word = 0; upset_mask = 0; vin = 0;
        cnt_event = 0; ring_tick = 0; ring_ss = 0; global_pulse = 0;
        pix_rdata = 0; seed = 32'h2eed; miscompares = 0; cmp_count = 0;
        cyc = 0;
        hold(3);
        rst = 0;
        rd(OFS_CFG, d);
        chk(d, CFG_RESET);
        u_cmd.clear_counters();
        for (int i = 0; i < 10; i++) begin
            a = (i < 8) ? OFS_CFG + 9'(i) : OFS_SCRATCH + 9'(i - 8);
            exp_cfg[i] = 16'($random(seed));
            u_cmd.write_reg(a, exp_cfg[i]);
            rd(a, d);
            chk(d, exp_cfg[i]);
        end
        $display("test read write done");
        upset_word = 3'h4;
        upset_copy = 2'($unsigned($random(seed)) % 3);
        upset_mask = 16'($random(seed)) | 16'h0001; sea = 1;
        hold(1);
        sea = 0;
        rd(OFS_CFG + 9'h004, d);
        chk(d, exp_cfg[4]);
        rd(OFS_CNT, d);
        chk(d, 16'h0001);
        $display("test upset done");
        pix_rdata = 16'($random(seed));
        rd(OFS_PORTAL, d);
        chk(d, pix_rdata);
        chk(rd_ext_addr, {1'b1, exp_cfg[0][8:0]});
        chk(pix_row, exp_cfg[CFG_ROW]);
        chk(pix_col, exp_cfg[CFG_COL]);
        w = 16'($random(seed));
        u_cmd.req(1'b1, 1'b0, OFS_PORTAL, w);
        #1;
        chk(pix_wr, 1);
        chk(pix_wdata, w);
        u_cmd.req(1'b0, 1'b0, OFS_PORTAL, w);
        $display("test portal done");
        for (int k = 0; k < 32; k += 31) begin
            u_cmd.write_reg(OFS_CFG + 9'h002, 16'(k));
            chk(onehot, 32'h1 << k);
        end
        cnt_event = 15'h0008;
        hold(5);
        cnt_event = 0;
        rd(OFS_CNT + 9'h003, d);
        chk(d, 16'h0005);
        cnt_event = 15'h0088;
        u_cmd.req(1'b1, 1'b0, OFS_CNT + 9'h003, 16'($random(seed)));
        u_cmd.read_reg(OFS_CNT + 9'h003, d, v);
        chk(d, 16'h0000);
        hold(65540);
        rd(OFS_CNT + 9'h007, d);
        chk(d, 16'hffff);
        cnt_event = 0;
        $display("test counters done");
        ring_tick = 8'h04; ring_ss = 8'h04;
        hold(3);
        ring_ss = 0;
        hold(6);
        ring_tick = 0;
        rd(OFS_RING + 9'h002, d);
        chk(d, osc_word(3, 9));
        u_cmd.write_reg(OFS_RING + 9'h002, 16'h0000);
        rd(OFS_RING + 9'h002, d);
        chk(d, osc_word(3, 9));
        global_pulse = 1;
        hold(1);
        global_pulse = 0;
        rd(OFS_RING + 9'h002, d);
        chk(d, 16'h0000);
        $display("test oscillator done");
        vin = 12'($random(seed));
        hold(128 * 30);
        rd(OFS_ADC, d);
        chk(d[11:0], vin);
        u_cmd.write_reg(OFS_ADC, ~d);
        rd(OFS_ADC, w);
        chk(w, d);
        rd(9'h1ff, d);
        chk(d, UNMAPPED_READ);
        $display("test converter done");
        tally_and_finish();
    end
endmodule
